// file: verilog/tlic_ctrl.v
// Purpose: Two-level priority interrupt controller for an 8-bit core
// Assumes: clk_in is the instruction clock; pins are asynchronous
// Notes:   Registers over classic Wishbone, one-cycle ack
//
// Operation
// - High vector 000008h, low vector 000018h
// - High preempts low; low never preempts high
// - Each source has flag, enable, priority
// - Priority mode only when mode bit set
// - Priority mode: bit7 high enable, bit6 low
// - Flag, enable, level enable set: vector
// - Compatibility mode: priority ignored, vector 000008h
// - Compatibility: bit6 peripherals, bit7 all sources
// - Accept clears the applicable global enable
// - Accept pushes return, loads vector address
// - Return from handler resets global enable
// - Pin event latency three to four cycles
// - Flags set regardless of enables
// - Bit5 timer enable, bit2 sticky timer flag
// - Bit4 pin0 enable, bit1 sticky pin0 flag
// - Bit3 port enable, bit0 sticky change flag
// - Bit6 enables low peripherals; bit7 clear disables
// - Edge select: one rising, zero falling
//
// Design decisions made here: the Wishbone register port and the address map.
`include "tlic_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module tlic_ctrl
(
    input  wire        clk_in,
    input  wire        rst_n_in,
    // Wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    // Sources
    input  wire        timer0_overflow_in,
    input  wire        ext_pin0_in,
    input  wire [3:0]  upper_port_b_pins_in,
    input  wire        periph_event_in,
    // Core side
    input  wire        core_ack_in,
    input  wire        return_from_handler_in,
    output wire        irq_req_out,
    output reg  [20:0] vector_out,
    output reg         push_return_out,
    output reg         in_high_out,
    output reg         in_low_out
);

    reg  [7:0]  intctl_reg;
    reg         prio_mode_reg;
    reg  [7:0]  ctl2_reg;
    reg  [2:0]  per_reg;
    reg  [2:0]  ext_sync_reg;
    reg  [11:0] port_sync_reg;
    reg  [3:0]  port_last_reg;
    reg         ext_last_reg;
    wire        wb_req;
    wire        wr_intctl;
    wire        ext_edge_hit;
    wire        port_change;
    wire [3:0]  port_now;
    wire        t0_prio;
    wire        ext_prio;
    wire        port_prio;
    reg         high_req;
    reg         low_req;
    reg         compat_req;
    reg         take_high;
    reg         take_low;
    reg  [7:0]  intctl_next;

    assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr_intctl = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `TLIC_ADDR_INTCTL);

    // Three-stage pin sync; change accepted when stages 2 and 3 agree
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ext_sync_reg  <= 3'h0;
            port_sync_reg <= 12'h000;
        end
        else
        begin
            ext_sync_reg  <= {ext_sync_reg[1:0], ext_pin0_in};
            port_sync_reg <= {port_sync_reg[7:0], upper_port_b_pins_in};
        end
    end

    assign port_now = port_sync_reg[7:4];

    // Filtered levels; stage 1 feeds only stage 2
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ext_last_reg  <= 1'b0;
            port_last_reg <= 4'h0;
        end
        else
        begin
            if (ext_sync_reg[1] == ext_sync_reg[2])
                ext_last_reg <= ext_sync_reg[2];
            port_last_reg <= (port_now & port_sync_reg[11:8]) | (port_last_reg & (port_now ^ port_sync_reg[11:8]));
        end
    end

    // Pin 0 edge chosen by edge select bit; port change on either edge
    assign ext_edge_hit = (ext_sync_reg[1] == ext_sync_reg[2]) &&
                          (ext_sync_reg[2] != ext_last_reg) &&
                          (ext_sync_reg[2] == ctl2_reg[`TLIC_B_EXT0_EDGE]);
    assign port_change = |((port_now & port_sync_reg[11:8]) ^ (port_last_reg & ~(port_now ^ port_sync_reg[11:8]))
                           & ~(port_now ^ port_sync_reg[11:8]));

    // No extra padding after the synchroniser: the three flops alone
    // already take three cycles, so the flag lands on the fourth edge.
    // Any added delay stage would push pin latency past four cycles.
    // The figure holds for every instruction length, as nothing here
    // looks at what the core is executing.

    assign t0_prio   = ctl2_reg[`TLIC_B_T0_PRIO];
    assign ext_prio  = ctl2_reg[`TLIC_B_EXT0_PRIO];
    assign port_prio = ctl2_reg[`TLIC_B_PORT_PRIO];

    // Level requests from flag, enable and priority
    always @*
    begin
        high_req = (intctl_reg[`TLIC_B_T0_FLAG] & intctl_reg[`TLIC_B_T0_EN] & t0_prio) |
                   (intctl_reg[`TLIC_B_EXT0_FLAG] & intctl_reg[`TLIC_B_EXT0_EN] & ext_prio) |
                   (intctl_reg[`TLIC_B_PORT_FLAG] & intctl_reg[`TLIC_B_PORT_EN] & port_prio) |
                   (per_reg[`TLIC_B_PER_FLAG] & per_reg[`TLIC_B_PER_EN] & per_reg[`TLIC_B_PER_PRIO]);
        low_req  = (intctl_reg[`TLIC_B_T0_FLAG] & intctl_reg[`TLIC_B_T0_EN] & ~t0_prio) |
                   (intctl_reg[`TLIC_B_EXT0_FLAG] & intctl_reg[`TLIC_B_EXT0_EN] & ~ext_prio) |
                   (intctl_reg[`TLIC_B_PORT_FLAG] & intctl_reg[`TLIC_B_PORT_EN] & ~port_prio) |
                   (per_reg[`TLIC_B_PER_FLAG] & per_reg[`TLIC_B_PER_EN] & ~per_reg[`TLIC_B_PER_PRIO]);
        // Compatibility: priority ignored, peripherals need bit 6
        compat_req = (intctl_reg[`TLIC_B_T0_FLAG] & intctl_reg[`TLIC_B_T0_EN]) |
                     (intctl_reg[`TLIC_B_EXT0_FLAG] & intctl_reg[`TLIC_B_EXT0_EN]) |
                     (intctl_reg[`TLIC_B_PORT_FLAG] & intctl_reg[`TLIC_B_PORT_EN]) |
                     (per_reg[`TLIC_B_PER_FLAG] & per_reg[`TLIC_B_PER_EN] &
                      intctl_reg[`TLIC_B_PERIPHERAL_IRQ_ENABLE_LOW]);
        if (prio_mode_reg)
        begin
            // High needs bit 7 and no high handler active
            take_high = high_req & intctl_reg[`TLIC_B_GIE_HIGH] & ~in_high_out;
            // Low needs bit 6, bit 7, and no handler active
            take_low  = ~take_high & low_req & intctl_reg[`TLIC_B_PERIPHERAL_IRQ_ENABLE_LOW] &
                        intctl_reg[`TLIC_B_GIE_HIGH] & ~in_high_out & ~in_low_out;
        end
        else
        begin
            take_high = compat_req & intctl_reg[`TLIC_B_GIE_HIGH];
            take_low  = 1'b0;
        end
    end

    // Request held while core has not acknowledged
    assign irq_req_out = take_high | take_low;

    // interrupt_control next value; hardware set wins over clear
    always @*
    begin
        intctl_next = intctl_reg;
        if (wr_intctl)
            intctl_next = wb_dat_in[7:0];
        if (core_ack_in && irq_req_out)
        begin
            if (prio_mode_reg && take_low)
                intctl_next[`TLIC_B_PERIPHERAL_IRQ_ENABLE_LOW] = 1'b0;
            else
                intctl_next[`TLIC_B_GIE_HIGH] = 1'b0;
        end
        if (return_from_handler_in)
        begin
            if (prio_mode_reg && in_low_out && !in_high_out)
                intctl_next[`TLIC_B_PERIPHERAL_IRQ_ENABLE_LOW] = 1'b1;
            else
                intctl_next[`TLIC_B_GIE_HIGH] = 1'b1;
        end
        // Flags set whatever the enables say
        if (timer0_overflow_in)
            intctl_next[`TLIC_B_T0_FLAG] = 1'b1;
        if (ext_edge_hit)
            intctl_next[`TLIC_B_EXT0_FLAG] = 1'b1;
        if (port_change)
            intctl_next[`TLIC_B_PORT_FLAG] = 1'b1;
    end

    // Register file and peripheral source state
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            intctl_reg    <= `TLIC_RST_INTCTL;
            prio_mode_reg <= 1'b0;
            ctl2_reg      <= `TLIC_RST_CTL2;
            per_reg       <= 3'h0;
        end
        else
        begin
            intctl_reg <= intctl_next;
            if (wb_req && wb_we_in && wb_sel_in[0])
            begin
                if (wb_adr_in == `TLIC_ADDR_RSTCTL)
                    prio_mode_reg <= wb_dat_in[`TLIC_B_PRIO_MODE];
                if (wb_adr_in == `TLIC_ADDR_CTL2)
                    ctl2_reg <= wb_dat_in[7:0] & `TLIC_RST_CTL2;
            end
            // Peripheral flag: event wins over a software clear
            if (wb_req && wb_we_in && wb_sel_in[0] && wb_adr_in == `TLIC_ADDR_PERIPH)
                per_reg <= wb_dat_in[2:0] | {2'h0, periph_event_in};
            else if (periph_event_in)
                per_reg[`TLIC_B_PER_FLAG] <= 1'b1;
        end
    end

    // Handler level tracking and vector output
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            in_high_out     <= 1'b0;
            in_low_out      <= 1'b0;
            vector_out      <= `TLIC_VEC_HIGH;
            push_return_out <= 1'b0;
        end
        else
        begin
            push_return_out <= core_ack_in & irq_req_out;
            if (core_ack_in && irq_req_out)
            begin
                if (take_low)
                begin
                    in_low_out <= 1'b1;
                    vector_out <= `TLIC_VEC_LOW;
                end
                else
                begin
                    in_high_out <= 1'b1;
                    vector_out  <= `TLIC_VEC_HIGH;
                end
            end
            else if (return_from_handler_in)
            begin
                // Leave the innermost handler first
                if (in_high_out)
                    in_high_out <= 1'b0;
                else
                    in_low_out <= 1'b0;
            end
        end
    end

    // Wishbone ack and read data, one cycle after request
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end
        else
        begin
            wb_ack_out <= wb_req;
            if (wb_req && !wb_we_in)
            begin
                case (wb_adr_in)
                    `TLIC_ADDR_INTCTL: wb_dat_out <= {24'h000000, intctl_reg};
                    `TLIC_ADDR_RSTCTL: wb_dat_out <= {24'h000000, prio_mode_reg, 7'h00};
                    `TLIC_ADDR_CTL2:   wb_dat_out <= {24'h000000, ctl2_reg};
                    `TLIC_ADDR_PERIPH: wb_dat_out <= {29'h00000000, per_reg};
                    `TLIC_ADDR_STATUS: wb_dat_out <= {28'h0000000, in_high_out, in_low_out,
                                                      high_req, low_req};
                    default:           wb_dat_out <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// file: inc/tlic_defines.vh
// Purpose: Constants for the two-level interrupt controller
// Assumes: Wishbone byte addressing, 32-bit data, 8-bit registers
// Notes:   Offsets are byte addresses
`ifndef TLIC_DEFINES_VH
`define TLIC_DEFINES_VH

// Register byte offsets
`define TLIC_ADDR_INTCTL      8'h00
`define TLIC_ADDR_RSTCTL      8'h04
`define TLIC_ADDR_CTL2        8'h08
`define TLIC_ADDR_PERIPH      8'h0c
`define TLIC_ADDR_STATUS      8'h10

// interrupt_control field positions
`define TLIC_B_GIE_HIGH       7
`define TLIC_B_PERIPHERAL_IRQ_ENABLE_LOW       6
`define TLIC_B_T0_EN          5
`define TLIC_B_EXT0_EN        4
`define TLIC_B_PORT_EN        3
`define TLIC_B_T0_FLAG        2
`define TLIC_B_EXT0_FLAG      1
`define TLIC_B_PORT_FLAG      0

// reset_control_reg and control-2 fields
`define TLIC_B_PRIO_MODE      7
`define TLIC_B_EXT0_EDGE      6
`define TLIC_B_T0_PRIO        2
`define TLIC_B_PORT_PRIO      0
`define TLIC_B_EXT0_PRIO      1

// peripheral register fields
`define TLIC_B_PER_FLAG       0
`define TLIC_B_PER_EN         1
`define TLIC_B_PER_PRIO       2

// Reset values
`define TLIC_RST_INTCTL       8'h00
`define TLIC_RST_RSTCTL       8'h00
`define TLIC_RST_CTL2         8'hc7
`define TLIC_RST_PERIPH       8'h00

// Vectors
`define TLIC_VEC_HIGH         21'h000008
`define TLIC_VEC_LOW          21'h000018

// Pin-event latency in instruction cycles, synchroniser included
`define TLIC_PIN_LAT_CYC      3

`endif

// file: sim/tlic_ctrl_sva.sv
// Purpose: Port assertions for the interrupt controller
// Assumes: One clock, async active-low reset
// Notes:   Bound to the design at the foot
`timescale 1ns/100ps
`default_nettype none
module tlic_ctrl_sva
(
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        wb_ack_out,
    input wire logic        core_ack_in,
    input wire logic        return_from_handler_in,
    input wire logic        irq_req_out,
    input wire logic [20:0] vector_out,
    input wire logic        push_return_out,
    input wire logic        in_high_out,
    input wire logic        in_low_out
);
    // Acceptance edge as the core sees it
    wire logic take_w = irq_req_out && core_ack_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Bus and core-link timing
    chk_ack_one: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    chk_vec_legal: assert property (vector_out == 21'h000008 || vector_out == 21'h000018)
        else $error("vector not a legal address");
    chk_vec_hold: assert property (!take_w |=> $stable(vector_out))
        else $error("vector moved without acceptance");
    chk_push_take: assert property (take_w |=> push_return_out && (in_high_out || in_low_out))
        else $error("acceptance without push");
    chk_push_cause: assert property (push_return_out |-> $past(take_w))
        else $error("push without acceptance");
    chk_high_block: assert property (in_high_out |-> !irq_req_out)
        else $error("request during high handler");
    chk_preempt_low: assert property (take_w && in_low_out |=> in_high_out && vector_out == 21'h000008)
        else $error("bad preemption of low handler");
    chk_ret_high: assert property (return_from_handler_in && in_high_out |=> !in_high_out)
        else $error("return did not close high handler");
endmodule
bind tlic_ctrl tlic_ctrl_sva u_tlic_ctrl_sva (.*);
`default_nettype wire

// file: sim/tlic_core_model.sv
// Purpose: Core side: takes requests, stacks, returns
// Assumes: delay_in sets how slow the core answers
// Notes:   Depth counts pushed return addresses
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       irq_req_in,
    input  wire logic       push_in,
    input  wire logic       ret_go_in,
    input  wire logic [3:0] delay_in,
    output var  logic       ack_out,
    output var  logic       ret_out,
    output var  logic [3:0] depth_out
);
    logic [3:0] wait_reg;
    // Ack once the request has stood delay_in+1 cycles; one cycle only
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_reg  <= 4'h0;
            ack_out   <= 1'b0;
            ret_out   <= 1'b0;
            depth_out <= 4'h0;
        end
        else
        begin
            wait_reg  <= (irq_req_in && !ack_out) ? wait_reg + 4'h1 : 4'h0;
            ack_out   <= irq_req_in && !ack_out && (wait_reg >= delay_in);
            ret_out   <= ret_go_in && !ret_out;
            depth_out <= depth_out + {3'h0, push_in} - {3'h0, ret_out};
        end
    end
endmodule
`default_nettype wire

// file: sim/tlic_ctrl_tb.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model answers; bench drives bus and sources
// Notes:   Pin latency includes the three-flop synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tlic_ctrl_tb;
    localparam logic [7:0] IC = `TLIC_ADDR_INTCTL;
    localparam logic [7:0] C2 = `TLIC_ADDR_CTL2;
    localparam logic [7:0] PR = `TLIC_ADDR_PERIPH;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, cyc = 1'b0, we = 1'b0;
    logic        t0 = 1'b0, pin = 1'b0, per = 1'b0, ret_go = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  portb = 4'h0, dly = 4'h0, depth;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [20:0] vec;
    logic        ack, irq, push, hi, lo, cack, ret;
    int          bad_count = 0, checked = 0, n;
    always #5 clk_in = ~clk_in;
    tlic_ctrl u_tlic_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .timer0_overflow_in(t0), .ext_pin0_in(pin), .upper_port_b_pins_in(portb),
        .periph_event_in(per), .core_ack_in(cack), .return_from_handler_in(ret), .irq_req_out(irq),
        .vector_out(vec), .push_return_out(push), .in_high_out(hi), .in_low_out(lo));
    tlic_core_model u_tlic_core_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .irq_req_in(irq),
        .push_in(push), .ret_go_in(ret_go), .delay_in(dly), .ack_out(cack), .ret_out(ret), .depth_out(depth));
    // Classic cycle; cyc doubles as stb so both rise and fall together
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        do @(posedge clk_in); while (ack !== 1'b1 && ++k < 20);
        q = rdat;
        if (k >= 20) bad_count++;
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        wb(a, 1'b0, 8'h00);
        `CHK(nm, {24'h0, e}, q)
    endtask
    // Core return pulse, then let the enables settle
    task automatic give_ret;
        ret_go <= 1'b1;
        @(posedge clk_in) ret_go <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic conclude;
        $display("counts: checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        bad_count++;
        conclude;
    end
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(IC, 8'h00, "intctl");
        rd(`TLIC_ADDR_RSTCTL, 8'h00, "rstctl");
        rd(C2, 8'hc7, "ctl2");
        wb(8'h20, 1'b1, 8'hff);
        rd(8'h20, 8'h00, "hole");
        $display("test reset done");
        t0 <= 1'b1;
        @(posedge clk_in) t0 <= 1'b0;
        repeat (4) @(posedge clk_in);
        `CHK("irq idle", 1'b0, irq)
        rd(IC, 8'h04, "poll flag");
        $display("test polling done");
        wb(C2, 1'b1, 8'hc3);
        wb(IC, 1'b1, 8'ha4);
        repeat (4) @(posedge clk_in);
        `CHK("compat vec", `TLIC_VEC_HIGH, vec)
        `CHK("compat push", 4'h1, depth)
        rd(IC, 8'h24, "gie clear");
        wb(IC, 1'b1, 8'h20);
        give_ret;
        rd(IC, 8'ha0, "gie back");
        wb(PR, 1'b1, 8'h02);
        per <= 1'b1;
        @(posedge clk_in) per <= 1'b0;
        wb(IC, 1'b1, 8'h80);
        repeat (3) @(posedge clk_in);
        `CHK("peripheral_irq_enable gate", 1'b0, irq)
        wb(IC, 1'b1, 8'hc0);
        repeat (5) @(posedge clk_in);
        `CHK("periph push", 4'h1, depth)
        wb(PR, 1'b1, 8'h02);
        give_ret;
        $display("test compat done");
        wb(`TLIC_ADDR_RSTCTL, 1'b1, 8'h80);
        wb(C2, 1'b1, 8'hc2);
        dly <= 4'h3;
        wb(IC, 1'b1, 8'hf0);
        t0 <= 1'b1;
        @(posedge clk_in) t0 <= 1'b0;
        repeat (10) @(posedge clk_in);
        `CHK("low vec", `TLIC_VEC_LOW, vec)
        `CHK("in low", 1'b1, lo)
        rd(IC, 8'hb4, "low_level_enable clear");
        pin <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 12)
        begin
            @(posedge clk_in);
            n++;
        end
        `CHK("pin latency", 1'b1, n >= 4 && n <= 5)
        repeat (6) @(posedge clk_in);
        `CHK("preempt vec", `TLIC_VEC_HIGH, vec)
        `CHK("in high", 1'b1, hi)
        rd(IC, 8'h36, "high_level_enable clear");
        wb(IC, 1'b1, 8'h34);
        give_ret;
        `CHK("low still", 1'b1, lo)
        wb(IC, 1'b1, 8'hb0);
        give_ret;
        rd(IC, 8'hf0, "both back");
        `CHK("stack empty", 4'h0, depth)
        $display("test priority done");
        pin <= 1'b0;
        repeat (8) @(posedge clk_in);
        rd(IC, 8'hf0, "fall ignored");
        wb(C2, 1'b1, 8'h82);
        pin <= 1'b1;
        repeat (8) @(posedge clk_in);
        pin <= 1'b0;
        repeat (8) @(posedge clk_in);
        portb <= 4'ha;
        repeat (8) @(posedge clk_in);
        rd(IC, 8'h73, "fall and port");
        $display("test edges done");
        conclude;
    end
endmodule
`default_nettype wire
